//--- rtl/psm_mgmt_regs.sv
// Purpose: control and status register bank behind the serial management port
// Assumes: core status inputs are on clock; straps and SPI are asynchronous
// Notes:   long carrier time is a parameter so benches can shorten it
`include "psm_defs.svh"
`default_nettype none
module psm_mgmt_regs #(
  parameter int SHORT_CD_CYCLES = (`PSM_SHORT_CD_NS + `PSM_CLK_PERIOD_NS - 1)
                                  / `PSM_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // serial management link
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output logic            spi_sdo,
  output logic            spi_sdo_oe_n,
  // strap pins
  input  wire logic       speed_strap_pin,
  input  wire logic       power_strap_pin,
  input  wire logic       command_accept_strap_pin,
  // core status
  input  wire logic       rx_power_level,
  input  wire logic       rx_speed_level,
  input  wire logic       carrier_detect,
  input  wire logic       bad_sync,
  input  wire logic       in_packet,
  input  wire logic [7:0] noise_level,
  input  wire logic       rmt_rx_valid,
  input  wire logic [3:0] rmt_rx_code,
  // core control
  output logic            stop_addr_negotiation,
  output logic            clear_noise_events,
  output logic            slice_adapt_disable,
  output logic            sleep_request,
  output logic            sm_restart,
  output logic            tx_speed_high,
  output logic            tx_power_high,
  output logic            peak_average_rule,
  output logic            short_carrier_rule_enable,
  output logic            noise_raise_disable,
  output logic [8:0]      slice_level,
  output logic [8:0]      peak_ref_level,
  output logic            bad_sync_count,
  output logic            rmt_rx_accept,
  output logic            rmt_cmd_send,
  output logic [3:0]      rmt_cmd_code
);
  psm_xfer_if xfer ();  // crossing bundle

  psm_spi_link u_link (
    .rst          (rst),
    .spi_sck      (spi_sck),
    .spi_cs_n     (spi_cs_n),
    .spi_sdi      (spi_sdi),
    .spi_sdo      (spi_sdo),
    .spi_sdo_oe_n (spi_sdo_oe_n),
    .bus          (xfer.link)
  );

  psm_pkg::psm_byte_t main_control, next_main_control;
  psm_pkg::psm_byte_t command_and_noise_control, next_command_and_noise_control;
  psm_pkg::psm_byte_t rd_data, next_rd_data;  // answer to the link
  logic               rd_ack, next_rd_ack;
  logic [2:0]         wr_sync, rd_sync;  // [0] meta, [1] sync, [2] previous
  logic [1:0]         spd_sync, pwr_sync, cmd_sync;  // strap synchronisers
  logic [1:0]         strap_cnt, next_strap_cnt;  // settles the strap syncs
  logic [15:0]        cd_cnt, next_cd_cnt;  // carrier detect duration
  logic               next_sm_restart, next_tx_speed, next_tx_power;
  logic               next_bad_sync_count, next_rmt_accept, next_rmt_send;
  logic [3:0]         next_rmt_code;
  logic               wr_hit, rd_hit, strap_load, cd_long;
  logic [8:0]         noise_raw, noise_raised;

  // synchronisers: only the second stage and beyond feed logic
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_sync  <= 3'h0;
      rd_sync  <= 3'h0;
      spd_sync <= 2'h0;
      pwr_sync <= 2'h0;
      cmd_sync <= 2'h0;
    end else begin
      wr_sync  <= {wr_sync[1:0], xfer.wr_toggle};
      rd_sync  <= {rd_sync[1:0], xfer.rd_toggle};
      spd_sync <= {spd_sync[0], speed_strap_pin};
      pwr_sync <= {pwr_sync[0], power_strap_pin};
      cmd_sync <= {cmd_sync[0], command_accept_strap_pin};
    end
  end

  assign wr_hit       = wr_sync[2] ^ wr_sync[1];  // a write frame finished
  assign rd_hit       = rd_sync[2] ^ rd_sync[1];  // a read frame asks
  assign strap_load   = (strap_cnt == `PSM_STRAP_LOAD);
  assign cd_long      = (cd_cnt >= 16'(SHORT_CD_CYCLES));
  assign noise_raw    = {1'b0, noise_level};
  assign noise_raised = noise_raw + {3'h0, noise_level[7:2]};  // noise plus 25%

  // next values of registers, strobes and core controls
  always_comb begin
    next_main_control              = main_control;
    next_command_and_noise_control = command_and_noise_control;
    next_strap_cnt = strap_load ? strap_cnt + 2'h1 : strap_cnt;
    if (strap_cnt < `PSM_STRAP_LOAD) begin
      next_strap_cnt = strap_cnt + 2'h1;
    end
    // straps land once the sync pipes hold settled levels
    if (strap_load) begin
      next_main_control[`PSM_M_SPEED]             = spd_sync[1];  // RULE7
      next_main_control[`PSM_M_POWER]             = pwr_sync[1];  // RULE8
      next_command_and_noise_control[`PSM_C_IGNORE] = cmd_sync[1];  // RULE10
    end
    // an accepted remote command steers local speed and power
    next_rmt_accept = rmt_rx_valid & ~command_and_noise_control[`PSM_C_IGNORE];  // RULE9
    if (next_rmt_accept) begin
      if (rmt_rx_code[3]) next_main_control[`PSM_M_POWER] = 1'b0;
      if (rmt_rx_code[2]) next_main_control[`PSM_M_POWER] = 1'b1;
      if (rmt_rx_code[1]) next_main_control[`PSM_M_SPEED] = 1'b0;
      if (rmt_rx_code[0]) next_main_control[`PSM_M_SPEED] = 1'b1;
    end
    // host writes win over straps and remote commands; status is not stored
    if (wr_hit && xfer.addr == `PSM_REG_MAIN) begin
      next_main_control = xfer.wr_data;  // RULE6
    end
    if (wr_hit && xfer.addr == `PSM_REG_CMD) begin
      next_command_and_noise_control = xfer.wr_data;
    end
    // leaving sleep keeps every register but restarts the core machine
    next_sm_restart = main_control[`PSM_M_SLEEP] & ~next_main_control[`PSM_M_SLEEP];  // RULE5
    // each write with a command bit set sends that command out
    next_rmt_send = wr_hit && xfer.addr == `PSM_REG_CMD && xfer.wr_data[3:0] != 4'h0;  // RULE16
    next_rmt_code = next_rmt_send ? xfer.wr_data[3:0] : rmt_cmd_code;
    // forcing bits override the selected level, low before high
    if (command_and_noise_control[`PSM_C_PWR_LO]) begin  // RULE14
      next_tx_power = 1'b0;
    end else if (command_and_noise_control[`PSM_C_PWR_HI]) begin
      next_tx_power = 1'b1;
    end else begin
      next_tx_power = main_control[`PSM_M_POWER];
    end
    if (command_and_noise_control[`PSM_C_SPD_LO]) begin  // RULE15
      next_tx_speed = 1'b0;
    end else if (command_and_noise_control[`PSM_C_SPD_HI]) begin
      next_tx_speed = 1'b1;
    end else begin
      next_tx_speed = main_control[`PSM_M_SPEED];
    end
    // carrier duration saturates so it never wraps during long carriers
    if (!carrier_detect) begin
      next_cd_cnt = 16'h0000;
    end else if (cd_long) begin
      next_cd_cnt = cd_cnt;
    end else begin
      next_cd_cnt = cd_cnt + 16'h0001;
    end
    next_bad_sync_count = bad_sync
                        & ~(command_and_noise_control[`PSM_C_SHORT_CD] & cd_long);  // RULE12
    // read answer captured once per read frame
    next_rd_data = rd_data;
    next_rd_ack  = rd_ack;
    if (rd_hit) begin
      next_rd_ack = rd_sync[1];
      unique case (xfer.addr)
        `PSM_REG_MAIN: next_rd_data = main_control;
        `PSM_REG_CMD:  next_rd_data = command_and_noise_control;
        `PSM_REG_STAT: begin  // RULE17 RULE18
          next_rd_data = {1'b0, rx_power_level, rx_speed_level, 5'h00};  // reserved bits read 0
        end
        default:       next_rd_data = 8'h00;  // unmapped reads as zero
      endcase
    end
  end

  // register stage of the bank
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_control              <= `PSM_MAIN_RST;
      command_and_noise_control <= `PSM_CMD_RST;
      strap_cnt      <= 2'h0;
      rd_data        <= 8'h00;
      rd_ack         <= 1'b0;
      cd_cnt         <= 16'h0000;
      sm_restart     <= 1'b0;
      tx_speed_high  <= 1'b0;
      tx_power_high  <= 1'b0;
      bad_sync_count <= 1'b0;
      rmt_rx_accept  <= 1'b0;
      rmt_cmd_send   <= 1'b0;
      rmt_cmd_code   <= 4'h0;
      slice_level    <= 9'h000;
      peak_ref_level <= 9'h000;
    end else begin
      main_control              <= next_main_control;
      command_and_noise_control <= next_command_and_noise_control;
      strap_cnt      <= next_strap_cnt;
      rd_data        <= next_rd_data;
      rd_ack         <= next_rd_ack;
      cd_cnt         <= next_cd_cnt;
      sm_restart     <= next_sm_restart;
      tx_speed_high  <= next_tx_speed;
      tx_power_high  <= next_tx_power;
      bad_sync_count <= next_bad_sync_count;
      rmt_rx_accept  <= next_rmt_accept;
      rmt_cmd_send   <= next_rmt_send;
      rmt_cmd_code   <= next_rmt_code;
      // in-packet raise can be dropped; peak reference may use raw noise
      slice_level    <= (command_and_noise_control[`PSM_C_NO_RAISE] && in_packet)
                        ? noise_raw : noise_raised;  // RULE13
      peak_ref_level <= command_and_noise_control[`PSM_C_PEAK_RULE]
                        ? noise_raw : noise_raised;  // RULE11
    end
  end

  // level controls straight from the register bits
  assign stop_addr_negotiation     = main_control[`PSM_M_STOP_NEG];  // RULE1
  assign clear_noise_events        = main_control[`PSM_M_CLR_NOISE];  // RULE2
  assign slice_adapt_disable       = main_control[`PSM_M_SLICE_DIS];  // RULE3
  assign sleep_request             = main_control[`PSM_M_SLEEP];  // RULE4
  assign peak_average_rule         = command_and_noise_control[`PSM_C_PEAK_RULE];
  assign short_carrier_rule_enable = command_and_noise_control[`PSM_C_SHORT_CD];
  assign noise_raise_disable       = command_and_noise_control[`PSM_C_NO_RAISE];
  assign xfer.rd_data              = rd_data;
  assign xfer.rd_ack               = rd_ack;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  strap_speed_a: assert property (strap_load && !wr_hit && !next_rmt_accept  // RULE7
    |=> main_control[`PSM_M_SPEED] == $past(spd_sync[1]))
    else $error("speed strap not loaded");
  strap_power_a: assert property (strap_load && !wr_hit && !next_rmt_accept  // RULE8
    |=> main_control[`PSM_M_POWER] == $past(pwr_sync[1]))
    else $error("power strap not loaded");
  strap_cmd_a: assert property (strap_load && !wr_hit  // RULE10
    |=> command_and_noise_control[`PSM_C_IGNORE] == $past(cmd_sync[1]))
    else $error("command strap not loaded");
  sleep_exit_a: assert property ($fell(sleep_request) |-> sm_restart ##1 !sm_restart)  // RULE5
    else $error("no restart pulse on wake");
  sleep_keep_a: assert property ($fell(sleep_request)  // RULE5
    |-> $stable(command_and_noise_control)) else $error("config lost on wake");
  pwr_force_a: assert property (command_and_noise_control[`PSM_C_PWR_LO]  // RULE14
    |=> !tx_power_high) else $error("power low not forced");
  spd_force_a: assert property (!command_and_noise_control[`PSM_C_SPD_LO]  // RULE15
    && command_and_noise_control[`PSM_C_SPD_HI] |=> tx_speed_high)
    else $error("speed high not forced");
  rmt_issue_a: assert property (wr_hit && xfer.addr == `PSM_REG_CMD  // RULE16
    && xfer.wr_data[3:0] != 4'h0 |=> rmt_cmd_send && rmt_cmd_code == $past(xfer.wr_data[3:0]))
    else $error("remote command not sent");
  rmt_ignore_a: assert property (command_and_noise_control[`PSM_C_IGNORE]  // RULE9
    |=> !rmt_rx_accept) else $error("remote command accepted while ignored");
  short_cd_a: assert property (short_carrier_rule_enable && cd_long && bad_sync  // RULE12
    |=> !bad_sync_count) else $error("bad sync counted on long carrier");
  no_raise_a: assert property (noise_raise_disable && in_packet  // RULE13
    |=> slice_level == $past(noise_raw)) else $error("noise raised inside packet");
  stat_read_a: assert property (rd_hit && xfer.addr == `PSM_REG_STAT  // RULE17 RULE18
    |=> rd_data[`PSM_S_RX_POWER_LEVEL] == $past(rx_power_level)
    && rd_data[`PSM_S_RX_SPEED_LEVEL] == $past(rx_speed_level) && rd_data[7] == 1'b0)
    else $error("status read wrong");

  write_main_c: cover property (wr_hit && xfer.addr == `PSM_REG_MAIN);
  read_stat_c: cover property (rd_hit && xfer.addr == `PSM_REG_STAT);
  wake_c: cover property (sm_restart);
  send_c: cover property (rmt_cmd_send ##[1:100] rmt_rx_accept);
endmodule
`default_nettype wire

//--- rtl/psm_defs.svh
// Purpose: constants of the serial management control and status bank
// Assumes: 40 MHz device clock; SPI frame = command byte, then data byte
// Notes:   read frames carry one turnaround byte before the data byte
// Behaviour
// RULE1 - bit 0.7 set halts address negotiation
// RULE2 - bit 0.6 set clears noise event counter
// RULE3 - bit 0.5 set freezes slice level adaptation
// RULE4 - bit 0.4 set puts device to sleep
// RULE5 - bit 0.4 cleared: wake, keep config, restart
// RULE6 - host writes bit 0.3 zero, 0.0 one
// RULE7 - bit 0.2 speed, loaded from speed strap
// RULE8 - bit 0.1 power, loaded from power strap
// RULE9 - bit 1.7 set discards incoming remote commands
// RULE10 - bit 1.7 loaded from command accept strap
// RULE11 - bit 1.6 averages peak with raw noise
// RULE12 - bit 1.5: long carrier skips bad sync
// RULE13 - bit 1.4: no noise raise inside packet
// RULE14 - bits 1.3/1.2 force transmit power low/high
// RULE15 - bits 1.1/1.0 force transmit speed low/high
// RULE16 - any command bit set sends remote command
// RULE17 - bit 2.6 shows received signal power
// RULE18 - bit 2.5 shows received speed
// RULE19 - host writes bit 2.7 zero, ignores it
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
// register offsets (7-bit address in the command byte)
`define PSM_REG_MAIN      7'h00
`define PSM_REG_CMD       7'h01
`define PSM_REG_STAT      7'h02
// main_control fields
`define PSM_M_STOP_NEG    7
`define PSM_M_CLR_NOISE   6
`define PSM_M_SLICE_DIS   5
`define PSM_M_SLEEP       4
`define PSM_M_SPEED       2
`define PSM_M_POWER       1
// command_and_noise_control fields
`define PSM_C_IGNORE      7
`define PSM_C_PEAK_RULE   6
`define PSM_C_SHORT_CD    5
`define PSM_C_NO_RAISE    4
`define PSM_C_PWR_LO      3
`define PSM_C_PWR_HI      2
`define PSM_C_SPD_LO      1
`define PSM_C_SPD_HI      0
// receive_status fields
`define PSM_S_RX_POWER_LEVEL      6
`define PSM_S_RX_SPEED_LEVEL      5
// reset values (strap bits overwritten once the straps are synchronised)
`define PSM_MAIN_RST      8'h05
`define PSM_CMD_RST       8'h00
// timing
`define PSM_CLK_PERIOD_NS 25
`define PSM_SHORT_CD_NS   160000
`define PSM_STRAP_LOAD    2'h2
`endif

//--- rtl/psm_pkg.sv
// Purpose: shared types of the serial management bank
// Assumes: constants live in psm_defs.svh
// Notes:   no values here, only types
`default_nettype none
package psm_pkg;
  typedef logic [7:0] psm_byte_t;  // one register or shift byte
  // phases of one SPI frame on the link clock
  typedef enum logic [2:0] {psm_ph_cmd, psm_ph_wdata, psm_ph_turn, psm_ph_rdata,
                            psm_ph_done} psm_phase_t;
endpackage
`default_nettype wire

//--- rtl/psm_xfer_if.sv
// Purpose: crossing bundle between the link engine and the register bank
// Assumes: toggles change once per frame, data held until the next frame
// Notes:   words are qualified by a synchronised toggle, never sampled raw
`default_nettype none
interface psm_xfer_if;
  logic              wr_toggle;  // flips once per write frame
  logic              rd_toggle;  // flips once per read frame
  logic [6:0]        addr;       // register address of the last frame
  psm_pkg::psm_byte_t wr_data;   // write data of the last write frame
  logic              rd_ack;     // copy of rd_toggle once rd_data is valid
  psm_pkg::psm_byte_t rd_data;   // read data, stable while rd_ack matches
  modport link (output wr_toggle, rd_toggle, addr, wr_data, input rd_ack, rd_data);
  modport bank (input wr_toggle, rd_toggle, addr, wr_data, output rd_ack, rd_data);
endinterface
`default_nettype wire

//--- rtl/psm_spi_link.sv
// Purpose: SPI shift engine running on the serial clock
// Assumes: mode 0, MSB first; sck only runs while cs_n is low
// Notes:   frame state is cleared by cs_n high, crossing state by rst only
`include "psm_defs.svh"
`default_nettype none
module psm_spi_link (
  // resets
  input  wire logic   rst,
  // link pins
  input  wire logic   spi_sck,
  input  wire logic   spi_cs_n,
  input  wire logic   spi_sdi,
  output var  logic   spi_sdo,
  output logic        spi_sdo_oe_n,
  // towards the bank
  psm_xfer_if.link    bus
);
  psm_pkg::psm_phase_t phase, next_phase;  // frame phase
  logic [2:0]          bit_cnt, next_bit_cnt;  // bit within the current byte
  logic [6:0]          shift_in, next_shift_in;  // incoming bits so far
  psm_pkg::psm_byte_t  tx_shift, next_tx_shift;  // outgoing read byte
  logic [6:0]          addr, next_addr;
  psm_pkg::psm_byte_t  wr_data, next_wr_data;
  logic                wr_tog, next_wr_tog;
  logic                rd_tog, next_rd_tog;
  logic                ack_meta, ack_sync;  // two-flop sync of rd_ack
  psm_pkg::psm_byte_t  byte_in;  // completed byte at the last bit

  // next state of the frame and of the held words
  always_comb begin
    byte_in       = {shift_in, spi_sdi};
    next_bit_cnt  = bit_cnt + 3'h1;
    next_shift_in = {shift_in[5:0], spi_sdi};
    next_phase    = phase;
    next_tx_shift = tx_shift;
    next_addr     = addr;
    next_wr_data  = wr_data;
    next_wr_tog   = wr_tog;
    next_rd_tog   = rd_tog;
    unique case (phase)
      psm_pkg::psm_ph_cmd: begin
        if (bit_cnt == 3'h7) begin
          next_addr = byte_in[6:0];
          if (byte_in[7]) begin  // read: ask the bank early
            next_rd_tog = ~rd_tog;
            next_phase  = psm_pkg::psm_ph_turn;
          end else begin
            next_phase = psm_pkg::psm_ph_wdata;
          end
        end
      end
      psm_pkg::psm_ph_wdata: begin
        if (bit_cnt == 3'h7) begin  // word and flag update on the same edge; the bank syncs the flag
          next_wr_data = byte_in;
          next_wr_tog  = ~wr_tog;
          next_phase   = psm_pkg::psm_ph_done;
        end
      end
      psm_pkg::psm_ph_turn: begin
        // eight link clocks give the bank ample time; a missed answer reads 0
        if (bit_cnt == 3'h7) begin
          next_tx_shift = (ack_sync == rd_tog) ? bus.rd_data : 8'h00;
          next_phase    = psm_pkg::psm_ph_rdata;
        end
      end
      psm_pkg::psm_ph_rdata: begin
        next_tx_shift = {tx_shift[6:0], 1'b0};
        if (bit_cnt == 3'h7) begin
          next_phase = psm_pkg::psm_ph_done;
        end
      end
      psm_pkg::psm_ph_done: begin
        next_phase = psm_pkg::psm_ph_done;  // extra clocks are ignored
      end
    endcase
  end

  // frame state, cleared between frames by the chip select itself
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      phase    <= psm_pkg::psm_ph_cmd;
      bit_cnt  <= 3'h0;
      shift_in <= 7'h00;
      tx_shift <= 8'h00;
    end else begin
      phase    <= next_phase;
      bit_cnt  <= next_bit_cnt;
      shift_in <= next_shift_in;
      tx_shift <= next_tx_shift;
    end
  end

  // held words and toggles survive the end of the frame
  always_ff @(posedge spi_sck or posedge rst) begin
    if (rst) begin
      addr     <= 7'h00;
      wr_data  <= 8'h00;
      wr_tog   <= 1'b0;
      rd_tog   <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      addr     <= next_addr;
      wr_data  <= next_wr_data;
      wr_tog   <= next_wr_tog;
      rd_tog   <= next_rd_tog;
      ack_meta <= bus.rd_ack;
      ack_sync <= ack_meta;
    end
  end

  // data out changes on the falling edge so the host samples it on the rising one
  always_ff @(negedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      spi_sdo <= 1'b0;
    end else begin
      spi_sdo <= tx_shift[7];
    end
  end

  assign spi_sdo_oe_n  = spi_cs_n | (phase != psm_pkg::psm_ph_rdata);
  assign bus.addr      = addr;
  assign bus.wr_data   = wr_data;
  assign bus.wr_toggle = wr_tog;
  assign bus.rd_toggle = rd_tog;
endmodule
`default_nettype wire

//--- tb/psm_spi_host.sv
// Purpose: host model on the serial management link
// Assumes: mode 0, msb first; link clock runs only inside frames
// Notes:   data line flips after a frame so a stale bit never looks valid
`default_nettype none
module psm_spi_host (
  // link pins
  output logic       spi_sck,
  output logic       spi_cs_n,
  output logic       spi_sdi,
  input  wire logic  spi_sdo,
  // read result towards the bench
  output logic [7:0] rd_byte,
  output logic       rd_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle link: clock low, not selected
  initial begin
    {spi_sck, spi_sdi, rd_strobe} = 3'h0;
    spi_cs_n = 1'b1;
    rd_byte  = 8'h00;
  end
  // one frame of n bits at 125 ns; bits from 16 on are read data
  task automatic frame(input logic [23:0] tx, input int n);
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_sdi = tx[23-i];
      #62.5 spi_sck = 1'b1;
      if (i >= 16) rd_byte = {rd_byte[6:0], spi_sdo};
      #62.5 spi_sck = 1'b0;
    end
    #62.5 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;          // released line shows the inverse
    rd_strobe = (n > 16);
    #125 rd_strobe = 1'b0;       // also keeps frames one period apart
  endtask
endmodule
`default_nettype wire

//--- tb/tb_phy_serial_mgmt_control_status.sv
// Purpose: self-checking bench of the serial management register bank
// Assumes: straps and status levels held steady while checked
// Notes:   carrier, packet and noise levels are random per forcing step
`default_nettype none
module tb_phy_serial_mgmt_control_status;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, rst, spi_sck, spi_cs_n, spi_sdi, spi_sdo, rd_strobe;
  logic       spd, pwr, cmd, rxp, rxs, rmt_rx_valid, rmt_cmd_send, sm_restart;
  logic       stop_neg, clr_ev, slc, slp, tx_spd, tx_pwr, peak, short_cd, no_raise, acc;
  logic       cd, bs, pkt, bsc, oe_n;  // carrier, bad sync, packet, counted sync, sdo enable
  logic [8:0] slice, peak_ref;         // noise thresholds seen at the outputs
  logic [15:0] up;                     // noise raised by a quarter
  logic [3:0] rmt_cmd_code;
  logic [7:0] noise_level, rd_byte, d;
  logic [7:0] exp_rd[$];         // expected read bytes, oldest first
  logic [3:0] exp_code[$];       // expected remote command codes
  int         err_count, compares, restarts, n0, oe_cnt;
  logic [31:0] rs;               // xorshift state
  psm_mgmt_regs #(.SHORT_CD_CYCLES(20)) u_psm_mgmt_regs (
    .clock(clock), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(oe_n),
    .speed_strap_pin(spd), .power_strap_pin(pwr), .command_accept_strap_pin(cmd),
    .rx_power_level(rxp), .rx_speed_level(rxs), .carrier_detect(cd),
    .bad_sync(bs), .in_packet(pkt), .noise_level(noise_level),
    .rmt_rx_valid(rmt_rx_valid), .rmt_rx_code(4'h4),
    .stop_addr_negotiation(stop_neg), .clear_noise_events(clr_ev),
    .slice_adapt_disable(slc), .sleep_request(slp), .sm_restart(sm_restart),
    .tx_speed_high(tx_spd), .tx_power_high(tx_pwr), .peak_average_rule(peak),
    .short_carrier_rule_enable(short_cd), .noise_raise_disable(no_raise),
    .slice_level(slice), .peak_ref_level(peak_ref), .bad_sync_count(bsc), .rmt_rx_accept(acc),
    .rmt_cmd_send(rmt_cmd_send), .rmt_cmd_code(rmt_cmd_code));
  psm_spi_host u_psm_spi_host (
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .rd_byte(rd_byte), .rd_strobe(rd_strobe));
  // 40 MHz device clock
  always #12.5 clock = ~clock;
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (exp_rd.size() != 0 || exp_code.size() != 0) err_count++;
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // write frame, then let the crossing land
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    u_psm_spi_host.frame({1'b0, a, v, 8'h00}, 16);
    repeat (8) @(posedge clock);
    #1;
  endtask
  // read frame; the watcher below compares the byte
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    u_psm_spi_host.frame({1'b1, a, 16'h0000}, 24);
    repeat (2) @(posedge clock);
    #1;
  endtask
  // one received remote command; acceptance within 4 cycles must match e
  task automatic rx_cmd(input logic e);
    logic seen;
    seen = 1'b0;
    rmt_rx_valid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      #1;
      rmt_rx_valid = 1'b0;
      if (acc === 1'b1) seen = 1'b1;
    end
    chk(seen, e);
  endtask
  // watchers take the oldest note whenever a result appears
  always @(posedge rd_strobe) begin
    if (exp_rd.size() == 0) chk(rd_byte, 8'hxx);
    else chk(rd_byte, exp_rd.pop_front());
    chk(16'(oe_cnt), 16'h0008);  // sdo driven for the data byte only
    oe_cnt = 0;
  end
  // count link falls at which the device drives sdo; writes must add none
  always @(negedge spi_sck) begin
    if (oe_n === 1'b0) oe_cnt++;
  end
  always @(negedge clock) begin
    if (sm_restart === 1'b1) restarts++;
    if (rmt_cmd_send === 1'b1) begin
      if (exp_code.size() == 0) chk(rmt_cmd_code, 8'hxx);
      else chk(rmt_cmd_code, exp_code.pop_front());
    end
  end
  // watchdog: a hang counts as a mismatch
  initial begin
    #1ms;
    err_count++;
    report_and_stop();
  end
  initial begin
    {clock, rmt_rx_valid, cd, bs, pkt, err_count, compares, restarts, oe_cnt} = '0;
    rs = 32'h25;
    rst = 1'b1;
    {spd, pwr, cmd, rxp, rxs} = 5'(rnd());
    noise_level = 8'(rnd());
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    repeat (6) @(posedge clock);
    rd(7'h00, {5'h00, spd, pwr, 1'b1});
    rd(7'h01, {cmd, 7'h00});
    // every pattern of the three main control levels
    for (int i = 0; i < 8; i++) begin
      d = {3'(i), 2'h0, 2'(rnd()), 1'b1};
      wr(7'h00, d);
      chk({stop_neg, clr_ev, slc, slp}, d[7:4]);
      rd(7'h00, d);
    end
    // sleep entry and exit keep the configuration
    wr(7'h01, 8'h70);
    n0 = restarts;
    wr(7'h00, 8'h15);
    chk(slp, 1'b1);
    chk(restarts, n0);
    wr(7'h00, 8'h05);
    chk({slp, 7'(restarts)}, 16'(n0 + 1));
    rd(7'h01, 8'h70);
    // each forcing command bit, with random noise options
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, 3'(rnd()), 4'h1 << i};
      {cd, pkt, noise_level} = 10'(rnd());  // carrier starts early so it is long at the check
      up = (16'(noise_level) * 16'h0005) >> 2;
      // selected levels opposite to the forced one, so forcing is visible
      wr(7'h00, {5'h00, i != 0, i != 2, 1'b1});
      exp_code.push_back(d[3:0]);
      wr(7'h01, d);
      chk({peak, short_cd, no_raise}, d[6:4]);
      if (i < 2) chk(tx_spd, i == 0);
      else chk(tx_pwr, i == 2);
      chk(peak_ref, d[6] ? 16'(noise_level) : up);
      chk(slice, (d[4] && pkt) ? 16'(noise_level) : up);
      bs = 1'b1;
      @(posedge clock);
      #1 bs = 1'b0;
      chk(bsc, !(d[5] && cd));
    end
    wr(7'h01, 8'h80);
    rx_cmd(1'b0);
    wr(7'h01, 8'h00);
    rx_cmd(1'b1);
    // status is read-only and tracks the receive levels
    {rxp, rxs} = 2'(rnd());
    wr(7'h02, 8'h60);
    rd(7'h02, {1'b0, rxp, rxs, 5'h00});
    wr(7'h05, 8'h5a);
    rd(7'h05, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
